// ==== include/ppmei_pkg.sv ====
/*
  ppmei_pkg: register map, field positions and reset values of the
  power-management event interrupt mask block.
  Assumes a 32-bit APB slave with byte addresses.
*/
package ppmei_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] PPMEI_STATUS_OFS = 16'hD094;
  localparam logic [15:0] PPMEI_MASK_OFS   = 16'hD098;
  localparam logic [15:0] PPMEI_CMD_OFS    = 16'hD09C;
  localparam int          PPMEI_ADDR_W     = 16;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PPMEI_PSC_BIT   = 24;
  localparam int PPMEI_PES_BIT   = 23;
  localparam int PPMEI_PCL_BIT   = 22;
  localparam int PPMEI_SPD_BIT   = 21;
  localparam int PPMEI_CMD_W     = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] PPMEI_MASK_RST = 4'h0;
  localparam logic [3:0] PPMEI_FLAG_RST = 4'h0;
  localparam logic [3:0] PPMEI_CMD_RST  = 4'h0;
endpackage : ppmei_pkg

// ==== design/ppmei_edge.sv ====
/*
  ppmei_edge: turns the host's config writes of the power-management
  control/status register into one-cycle event pulses.
  Assumes the write strobe and data are synchronous to sys_clk_i.
*/
`timescale 1ns/10ps
module ppmei_edge
  import ppmei_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // host power-management register writes
  input  wire logic       pmcsr_wr_i,
  input  wire logic [1:0] pmcsr_state_i,
  input  wire logic       pmcsr_pme_en_i,
  input  wire logic       pmcsr_pme_stat_clr_i,
  // event pulses
  output logic            ev_state_o,
  output logic            ev_pme_en_o,
  output logic            ev_pme_clr_o
);
  typedef struct packed {
    logic pme_en;
  } ppmei_edge_st_t;

  ppmei_edge_st_t st;
  ppmei_edge_st_t next_st;

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  // any write that carries the state field counts as a rewrite
  always_comb begin
    next_st = st;
    ev_state_o   = pmcsr_wr_i;
    ev_pme_en_o  = pmcsr_wr_i & pmcsr_pme_en_i & ~st.pme_en;
    ev_pme_clr_o = pmcsr_wr_i & pmcsr_pme_stat_clr_i;
    if (pmcsr_wr_i) begin
      next_st.pme_en = pmcsr_pme_en_i;
    end
  end

  // enable bit shadow
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  logic unused_state;
  assign unused_state = ^pmcsr_state_i;
endmodule : ppmei_edge

// ==== design/ppmei_apb.sv ====
/*
  ppmei_apb: APB slave front end, zero wait states, decodes the
  three register words and drops hit_o on an unmapped address.
  Assumes APB3 signalling on sys_clk_i.
*/
`timescale 1ns/10ps
module ppmei_apb
  import ppmei_pkg::*;
(
  // apb
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [PPMEI_ADDR_W-1:0] paddr_i,
  // decoded strobes
  output logic                         wr_status_o,
  output logic                         wr_mask_o,
  output logic [1:0]                   rd_sel_o,
  output logic                         hit_o
);
  logic acc;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    acc         = psel_i & penable_i;
    hit_o       = 1'b1;
    rd_sel_o    = 2'd0;
    wr_status_o = 1'b0;
    wr_mask_o   = 1'b0;
    unique case (paddr_i)
      PPMEI_STATUS_OFS: begin
        rd_sel_o    = 2'd1;
        wr_status_o = acc & pwrite_i;
      end
      PPMEI_MASK_OFS: begin
        rd_sel_o  = 2'd2;
        wr_mask_o = acc & pwrite_i;
      end
      PPMEI_CMD_OFS: rd_sel_o = 2'd3;
      default: hit_o = 1'b0;
    endcase
  end
endmodule : ppmei_apb

// ==== design/ppmei_top.sv ====
/*
  ppmei_top: power-management event flags, their interrupt enables,
  the bus-speed pin event and the current target command view.
  Assumes one clock, synchronous inputs and an APB master.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - state rewrite interrupts when bit 24 set
// - pme enable set interrupts when bit 23 set
// - pme status clear interrupts when bit 22
// - satellite mode: speed pin interrupt on bit 21
// - host mode: never a speed pin interrupt
// - bits 3:0 show current target command
// - state change flag set, write one clears
// - pme enable flag set on a write that turns enable from 0 to 1
// - power flags only meaningful in satellite mode
// - bit 21 status tracks speed pin live
module ppmei_top
  import ppmei_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  // apb slave
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [PPMEI_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic [31:0]                  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // controller state
  input  wire logic                    satellite_mode_i,
  input  wire logic                    bus_speed_pin_i,
  input  wire logic [PPMEI_CMD_W-1:0]  target_cmd_i,
  // host writes of the power-management register
  input  wire logic                    pmcsr_wr_i,
  input  wire logic [1:0]              pmcsr_state_i,
  input  wire logic                    pmcsr_pme_en_i,
  input  wire logic                    pmcsr_pme_stat_clr_i,
  // interrupt
  output logic                         irq_o
);
  typedef struct packed {
    logic [3:0]             mask;   // 3:psc 2:pes 1:pcl 0:spd
    logic [2:0]             flags;  // 2:psc 1:pes 0:pcl
    logic                   speed;
    logic [PPMEI_CMD_W-1:0] cmd;
    logic                   irq;
    logic [31:0]            rdata;
    logic                   slverr;
  } ppmei_st_t;

  ppmei_st_t st;
  ppmei_st_t next_st;

  logic       ev_state;
  logic       ev_pme_en;
  logic       ev_pme_clr;
  logic       wr_status;
  logic       wr_mask;
  logic [1:0] rd_sel;
  logic       hit;

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  ppmei_edge ppmei_edge_inst (
    .sys_clk_i            (sys_clk_i),
    .sys_rst_i            (sys_rst_i),
    .pmcsr_wr_i           (pmcsr_wr_i),
    .pmcsr_state_i        (pmcsr_state_i),
    .pmcsr_pme_en_i       (pmcsr_pme_en_i),
    .pmcsr_pme_stat_clr_i (pmcsr_pme_stat_clr_i),
    .ev_state_o           (ev_state),
    .ev_pme_en_o          (ev_pme_en),
    .ev_pme_clr_o         (ev_pme_clr)
  );

  ppmei_apb ppmei_apb_inst (
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .wr_status_o (wr_status),
    .wr_mask_o   (wr_mask),
    .rd_sel_o    (rd_sel),
    .hit_o       (hit)
  );

  // pack registers onto the word layout
  function automatic logic [31:0] ppmei_word(input logic [3:0] v);
    logic [31:0] w;
    w = 32'h0;
    w[PPMEI_PSC_BIT] = v[3];
    w[PPMEI_PES_BIT] = v[2];
    w[PPMEI_PCL_BIT] = v[1];
    w[PPMEI_SPD_BIT] = v[0];
    return w;
  endfunction : ppmei_word

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    logic [3:0] pend;
    logic [3:0] nm;
    ev = 3'h0;
    clr = 3'h0;
    pend = 4'h0;
    nm = 4'h0;
    next_st = st;
    // flags only latch in satellite mode
    ev = {ev_state, ev_pme_en, ev_pme_clr} & {3{satellite_mode_i}};
    if (wr_status) begin
      clr = {pwdata_i[PPMEI_PSC_BIT], pwdata_i[PPMEI_PES_BIT], pwdata_i[PPMEI_PCL_BIT]};
    end
    next_st.flags = (st.flags & ~clr) | ev;
    next_st.speed = bus_speed_pin_i;
    next_st.cmd   = target_cmd_i;
    if (wr_mask) begin
      // clearing bit 21 is how software withdraws the speed request
      next_st.mask = {pwdata_i[PPMEI_PSC_BIT], pwdata_i[PPMEI_PES_BIT],
                      pwdata_i[PPMEI_PCL_BIT], pwdata_i[PPMEI_SPD_BIT]};
    end
    nm = next_st.mask;
    pend[3] = next_st.flags[2] & nm[3];
    pend[2] = next_st.flags[1] & nm[2];
    pend[1] = next_st.flags[0] & nm[1];
    pend[0] = next_st.speed & nm[0] & satellite_mode_i;
    next_st.irq = |pend;
    next_st.slverr = psel_i & ~penable_i & ~hit;
    unique case (rd_sel)
      2'd1: next_st.rdata = ppmei_word({st.flags, st.speed});
      2'd2: next_st.rdata = ppmei_word(st.mask);
      2'd3: next_st.rdata = {28'h0, st.cmd};
      default: next_st.rdata = 32'h0;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st.mask   <= PPMEI_MASK_RST;
      st.flags  <= PPMEI_FLAG_RST[2:0];
      st.speed  <= 1'b0;
      st.cmd    <= PPMEI_CMD_RST;
      st.irq    <= 1'b0;
      st.rdata  <= 32'h0;
      st.slverr <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs; read data and error captured in setup, valid in access phase
  assign prdata_o  = st.rdata;
  assign pslverr_o = st.slverr; // cleared again at the access edge
  assign pready_o  = 1'b1;
  assign irq_o     = st.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_host_no_speed: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!$past(satellite_mode_i) && $past(st.flags) == 3'h0 && !$past(ev_state)
     && !$past(ev_pme_en) && !$past(ev_pme_clr)) |-> !irq_o)
    else $error("speed irq raised in host mode");
  a_mask_reset: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> st.mask == PPMEI_MASK_RST)
    else $error("mask not cleared by reset");
  a_state_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ev_state && satellite_mode_i) |=> st.flags[2])
    else $error("state change flag not set");
  a_pme_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ev_pme_en && satellite_mode_i) |=> st.flags[1])
    else $error("pme enable flag not set");
  a_speed_track: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    1'b1 |=> st.speed == $past(bus_speed_pin_i))
    else $error("speed status lags pin");
  a_cmd_track: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    1'b1 |=> st.cmd == $past(target_cmd_i))
    else $error("command view stale");
  a_speed_irq: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (satellite_mode_i && bus_speed_pin_i && st.mask[0] && !wr_mask) |=> irq_o)
    else $error("speed irq missing");
  a_mask_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (next_st.mask == 4'h0) |=> !irq_o)
    else $error("irq with all enables clear");
  a_clr_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_status && pwdata_i[PPMEI_PCL_BIT] && !ev_pme_clr) |=> !st.flags[0])
    else $error("clear flag survived write one");
endmodule : ppmei_top

// ==== test/ppmei_host_mdl.sv ====
/*
  ppmei_host_mdl: pci host side that writes the power-management
  control/status register, one write per cfg call.
  Assumes the caller enters cfg at a rising edge of sys_clk_i.
*/
`timescale 1ns/10ps
module ppmei_host_mdl (
  // clock
  input  wire logic       sys_clk_i,
  // config write of the pm register
  output logic            pmcsr_wr_o,
  output logic [1:0]      pmcsr_state_o,
  output logic            pmcsr_pme_en_o,
  output logic            pmcsr_pme_stat_clr_o
);
  // ------------------------------------------------------------
  // idle values
  // ------------------------------------------------------------
  initial begin
    pmcsr_wr_o = 1'b0;
    pmcsr_state_o = 2'h0;
    pmcsr_pme_en_o = 1'b0;
    pmcsr_pme_stat_clr_o = 1'b0;
  end

  // one-cycle write, data lines scrambled once it is over
  task automatic cfg(input logic [1:0] st, input logic en, input logic clr);
    pmcsr_wr_o <= 1'b1;
    pmcsr_state_o <= st;
    pmcsr_pme_en_o <= en;
    pmcsr_pme_stat_clr_o <= clr;
    @(posedge sys_clk_i);
    pmcsr_wr_o <= 1'b0;
    pmcsr_state_o <= ~st;
    pmcsr_pme_en_o <= ~en;
    pmcsr_pme_stat_clr_o <= ~clr;
    @(posedge sys_clk_i);
  endtask : cfg
endmodule : ppmei_host_mdl

// ==== test/pci_pm_event_irq_mask_tb_top.sv ====
/*
  pci_pm_event_irq_mask_tb_top: self-checking bench of ppmei_top.
  Assumes the design answers apb at once and the host model above.
*/
`timescale 1ns/10ps
module pci_pm_event_irq_mask_tb_top;
  import ppmei_pkg::*;
  logic        sys_clk = 1'b0, sys_rst = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, sat = 1'b0, pin = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, wr, en, clr;
  logic [1:0]  st;
  logic [3:0]  tcmd = 4'h0;
  int          fails = 0, compares = 0;

  // ------------------------------------------------------------
  // clock and instances
  // ------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;
  ppmei_host_mdl ppmei_host_mdl_inst (.sys_clk_i(sys_clk), .pmcsr_wr_o(wr),
    .pmcsr_state_o(st), .pmcsr_pme_en_o(en), .pmcsr_pme_stat_clr_o(clr));
  ppmei_top ppmei_top_inst (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .satellite_mode_i(sat), .bus_speed_pin_i(pin),
    .target_cmd_i(tcmd), .pmcsr_wr_i(wr), .pmcsr_state_i(st),
    .pmcsr_pme_en_i(en), .pmcsr_pme_stat_clr_i(clr), .irq_o(irq));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // setup, access until pready, release, one idle edge
  task automatic apb(logic w, logic [15:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pen <= 1'b0;
    @(posedge sys_clk);
    pen <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      fails++;
      test_done();
    end
    @(posedge sys_clk);
  endtask : apb

  task automatic wrr(logic [15:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wrr

  task automatic rdc(logic [15:0] a, logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", ex, r);
  endtask : rdc

  task automatic ck_irq(logic ex);
    @(posedge sys_clk);
    chk("irq_o", {31'h0, ex}, {31'h0, irq});
  endtask : ck_irq

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rdc(PPMEI_MASK_OFS, 32'h0);
    rdc(PPMEI_CMD_OFS, 32'h0);
    ck_irq(1'b0);
  endtask : t_reset

  task automatic t_flags;
    sat <= 1'b1;
    ppmei_host_mdl_inst.cfg(2'h3, 1'b0, 1'b0);
    rdc(PPMEI_STATUS_OFS, 32'h0100_0000);
    ck_irq(1'b0);
    wrr(PPMEI_MASK_OFS, 32'h0100_0000);
    ck_irq(1'b1);
    wrr(PPMEI_STATUS_OFS, 32'h0100_0000);
    ck_irq(1'b0);
    ppmei_host_mdl_inst.cfg(2'h0, 1'b1, 1'b1);
    rdc(PPMEI_STATUS_OFS, 32'h01C0_0000);
    for (int b = 22; b <= 24; b++) begin
      wrr(PPMEI_MASK_OFS, 32'h1 << b);
      ck_irq(1'b1);
    end
    wrr(PPMEI_MASK_OFS, 32'h0);
    ck_irq(1'b0);
    wrr(PPMEI_STATUS_OFS, 32'h01C0_0000);
    rdc(PPMEI_STATUS_OFS, 32'h0);
  endtask : t_flags

  task automatic t_host;
    sat <= 1'b0;
    pin <= 1'b1;
    ppmei_host_mdl_inst.cfg(2'h1, 1'b0, 1'b1);
    ppmei_host_mdl_inst.cfg(2'h2, 1'b1, 1'b1);
    rdc(PPMEI_STATUS_OFS, 32'h0020_0000);
    wrr(PPMEI_MASK_OFS, 32'h01E0_0000);
    ck_irq(1'b0);
  endtask : t_host

  task automatic t_speed;
    sat <= 1'b1;
    @(posedge sys_clk);
    ck_irq(1'b1);
    wrr(PPMEI_STATUS_OFS, 32'h0020_0000);
    rdc(PPMEI_STATUS_OFS, 32'h0020_0000);
    pin <= 1'b0;
    @(posedge sys_clk);
    ck_irq(1'b0);
    rdc(PPMEI_STATUS_OFS, 32'h0);
    pin <= 1'b1;
    @(posedge sys_clk);
    ck_irq(1'b1);
    wrr(PPMEI_MASK_OFS, 32'h0);
    ck_irq(1'b0);
  endtask : t_speed

  task automatic t_cmd;
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 16; i++) begin
      tcmd <= 4'(i);
      repeat (2) @(posedge sys_clk);
      rdc(PPMEI_CMD_OFS, 32'(i));
    end
    wrr(PPMEI_CMD_OFS, 32'h0);
    rdc(PPMEI_CMD_OFS, 32'h0000_000F);
    apb(1'b0, 16'hD0A0, 32'h0, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
    wrr(PPMEI_MASK_OFS, 32'hFFFF_FFFF);
    rdc(PPMEI_MASK_OFS, 32'h01E0_0000);
  endtask : t_cmd

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_flags();
    t_host();
    t_speed();
    t_cmd();
    test_done();
  end
endmodule : pci_pm_event_irq_mask_tb_top
